/* sfrc_cfg.svh */
// constants of the serial flash read and configuration write sequencer
// Function
// - write-enable command sets the latch; configuration write needs the latch set
// - configuration write is opcode plus one byte; other lengths discard it
// - chip select rise starts timed cycle, busy high, then busy and latch clear
// - busy flag stays readable during the timed cycle
// - single read samples address on rising edges, drives data on falling edges
// - read 03 takes three address bytes, streams until chip select rises
// - byte address advances after each byte and wraps to zero
// - fast read 0B takes address plus one dummy byte before data
// - fast, dual-output and dual-I/O reads are ignored while busy
// - dual-output read 3B: single-line address, 8 dummy clocks, two-bit data
// - dual-I/O read BB: address, mode byte and data two bits per clock, no dummy phase
// - dual-I/O read captures the mode byte right after the address
// - key bits 1,0 make next frame start with the address, no opcode
// - other key bits leave continuous mode at the next frame
// - continuous-read reset command clears the key bits
`ifndef SFRC_CFG_SVH
`define SFRC_CFG_SVH

// ---------------------------------------------------------------
// opcodes
// ---------------------------------------------------------------
`define SFRC_OP_READ   8'h03
`define SFRC_OP_FAST   8'h0b
`define SFRC_OP_DUAL_OUTPUT_READ_CMD  8'h3b
`define SFRC_OP_DIO    8'hbb
`define SFRC_OP_CFGWR  8'h01
`define SFRC_OP_WRITE_ENABLE_CMD   8'h06
`define SFRC_OP_WRDI   8'h04
`define SFRC_OP_MRST   8'hff

// ---------------------------------------------------------------
// phase lengths in serial clocks, last data-clock indices and the continuous key
// ---------------------------------------------------------------
`define SFRC_OPC_CLK   5'd8
`define SFRC_ADDR_X1   5'd24
`define SFRC_ADDR_X2   5'd12
`define SFRC_DUMMY_CLK 5'd8
`define SFRC_MODE_CLK  5'd4
`define SFRC_CFG_CLK   5'd16
`define SFRC_SGL_LAST  3'd7
`define SFRC_DUAL_LAST 3'd3
`define SFRC_KEY_CONT  2'b10

// ---------------------------------------------------------------
// sizes and timing
// ---------------------------------------------------------------
`define SFRC_ADDR_W    20
`define SFRC_TW_NS     5000000
`define SFRC_CLK_NS    5

`endif

/* sfrc_host.sv */
// host controller model driving the serial flash link
`timescale 1ns/1ps
`default_nettype none
module sfrc_host (
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_io0,
    output logic      o_io1,
    input  wire logic i_io0,
    input  wire logic i_io1
);
    // ------------------------------------------------
    // frame and bit tasks, sclk stands low between frames
    // ------------------------------------------------
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_io0 = 1'b0;
        o_io1 = 1'b1;
    end
    // data set while sclk low, taken at the rise
    task automatic bit2(input logic b1, input logic b0);
        o_io1 = b1;
        o_io0 = b0;
        #40 o_sclk = 1'b1;
        #40 o_sclk = 1'b0;
    endtask
    // byte on io0 msb first, io1 driven and toggled each bit
    task automatic tx1(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) bit2(~o_io1, v[i]);
    endtask
    // byte as pairs, io1 high bit
    task automatic tx2(input logic [7:0] v);
        for (int i = 3; i >= 0; i--) bit2(v[2*i+1], v[2*i]);
    endtask
    // lines toggled each bit, sampled at each rise
    task automatic rx(input bit dual, output logic [7:0] v);
        v = 8'h00;
        for (int i = 0; i < (dual ? 4 : 8); i++) begin
            o_io0 = ~o_io0;
            o_io1 = ~o_io1;
            #40 o_sclk = 1'b1;
            v = dual ? {v[5:0], i_io1, i_io0} : {v[6:0], i_io1};
            #40 o_sclk = 1'b0;
        end
    endtask
    task automatic open_f;
        #1.3 o_cs_n = 1'b0;
        #40;
    endtask
    // cs rises right after the last whole byte
    task automatic close_f;
        #40 o_cs_n = 1'b1;
        #40;
    endtask
endmodule // sfrc_host
`default_nettype wire

/* sfrc_mem.sv */
// dual-clock byte array with registered read data
`timescale 1ns/1ps
`default_nettype none
module sfrc_mem #(
    parameter int AW = 20,
    parameter int DW = 8
) (
    input  wire logic          i_wclk,
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_waddr,
    input  wire logic [DW-1:0] i_wdata,
    input  wire logic          i_rclk,
    input  wire logic [AW-1:0] i_raddr,
    output logic      [DW-1:0] o_rdata
);

    logic [DW-1:0] mem_r [0:(1<<AW)-1];

    // load port on system clock
    always_ff @(posedge i_wclk) begin
        if (i_we) begin
            mem_r[i_waddr] <= i_wdata;
        end
    end

    // read port on serial clock
    always_ff @(posedge i_rclk) begin
        o_rdata <= mem_r[i_raddr];
    end

endmodule // sfrc_mem
`default_nettype wire

/* sfrc_pkg.sv */
// types of the serial flash read and configuration write sequencer
`default_nettype none
package sfrc_pkg;

    // ---------------------------------------------------------------
    // link-side frame states
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {ls_start, ls_opc, ls_addr, ls_mode, ls_dummy, ls_data, ls_ign} sfrc_st_t;

endpackage
`default_nettype wire

/* sfrc_seq.sv */
// serial flash read sequencer and configuration write control
`timescale 1ns/1ps
`default_nettype none
`include "sfrc_cfg.svh"
module sfrc_seq import sfrc_pkg::*; #(
    parameter int ADDR_W    = `SFRC_ADDR_W,
    parameter int TW_CYCLES = (`SFRC_TW_NS + `SFRC_CLK_NS - 1) / `SFRC_CLK_NS
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire logic              i_sclk,
    input  wire logic              i_cs_n,
    input  wire logic              i_io0,
    input  wire logic              i_io1,
    output logic                   o_io0,
    output logic                   o_io0_oe_n,
    output logic                   o_io1,
    output logic                   o_io1_oe_n,
    input  wire logic              i_ext_busy,
    input  wire logic              i_ld_we,
    input  wire logic [ADDR_W-1:0] i_ld_addr,
    input  wire logic [7:0]        i_ld_data,
    output logic                   o_busy_flag,
    output logic                   o_wel,
    output logic      [7:0]        o_cfg_reg,
    output logic                   o_cfg_valid,
    output logic      [7:0]        o_cfg_data,
    input  wire logic              i_cfg_ready
);

    localparam int TW_W = $clog2(TW_CYCLES + 1);

    // ---------------------------------------------------------------
    // elaboration checks
    // ---------------------------------------------------------------
    if (ADDR_W < 8 || ADDR_W > 24) begin : g_bad_aw
        $error("ADDR_W must lie in 8..24");
    end
    if (TW_CYCLES < 1) begin : g_bad_tw
        $error("TW_CYCLES must be at least 1");
    end

    // gated reads are refused while a write cycle runs
    function automatic logic gated_rd(input logic [7:0] op);
        return (op == `SFRC_OP_FAST) || (op == `SFRC_OP_DUAL_OUTPUT_READ_CMD) || (op == `SFRC_OP_DIO);
    endfunction

    // ---------------------------------------------------------------
    // link domain declarations
    // ---------------------------------------------------------------
    sfrc_st_t    st_r, st_nxt;
    logic [4:0]  ph_r, ph_nxt, tot_r;
    logic [7:0]  opc_r, op_r, op_nxt, ign_r, dout_r, res_byte_r;
    logic [23:0] addr_r, addr_nxt;
    logic        a_dual_r, a_dual_nxt, d_dual_r, d_dual_nxt, dum_r, dum_nxt;
    logic [2:0]  dcnt_r, dcnt_nxt, ncnt_r;
    logic        drv_r, cont_r, frm_tgl_r;
    logic        bsy_s1_r, bsy_s2_r;
    logic        res_write_enable_cmd_r, res_wrdi_r, res_cfg_r;
    logic [7:0]  mem_q;

    wire         frame_rst = i_rst | i_cs_n;
    wire [7:0]   op_now    = {opc_r[6:0], i_io0};                        // msb first
    wire [4:0]   ph_inc    = ph_r + 5'd1;
    wire [4:0]   tot_inc   = (tot_r == 5'h1f) ? tot_r : tot_r + 5'd1;
    wire [2:0]   dmax      = d_dual_r ? `SFRC_DUAL_LAST : `SFRC_SGL_LAST;
    wire [23:0]  addr_inc  = addr_r + 24'd1;                             // wraps past top
    wire [23:0]  addr_sh   = a_dual_r ? {addr_r[21:0], i_io1, i_io0}     // io1 high bit
                                      : {addr_r[22:0], i_io0};           // rising-edge sample
    wire         opc_end   = (st_r == ls_opc) && (ph_inc == `SFRC_OPC_CLK);
    wire         mode_end  = (st_r == ls_mode) && (ph_inc == `SFRC_MODE_CLK);

    // ---------------------------------------------------------------
    // busy flag into the link domain
    // ---------------------------------------------------------------
    logic busy_any_r;
    always_ff @(posedge i_sclk or posedge i_rst) begin
        if (i_rst) begin
            bsy_s1_r <= 1'b0;
            bsy_s2_r <= 1'b0;
        end else begin
            bsy_s1_r <= busy_any_r;
            bsy_s2_r <= bsy_s1_r;
        end
    end

    // frame state decode
    always_comb begin
        st_nxt     = st_r;
        ph_nxt     = ph_inc;
        op_nxt     = op_r;
        addr_nxt   = addr_r;
        a_dual_nxt = a_dual_r;
        d_dual_nxt = d_dual_r;
        dum_nxt    = dum_r;
        dcnt_nxt   = dcnt_r;
        case (st_r)
            ls_start: begin
                if (cont_r) begin
                    // continuous frame starts straight with the address
                    a_dual_nxt = 1'b1;
                    d_dual_nxt = 1'b1;
                    addr_nxt   = {22'h0, i_io1, i_io0};
                    st_nxt     = ls_addr;                               // busy sync stale here
                end else begin
                    st_nxt = ls_opc;
                end
            end
            ls_opc: begin
                if (opc_end) begin
                    ph_nxt = 5'd0;
                    op_nxt = op_now;
                    st_nxt = ls_ign;
                    if (gated_rd(op_now) && bsy_s2_r) begin
                        st_nxt = ls_ign;
                    end else if (op_now == `SFRC_OP_READ) begin
                        st_nxt     = ls_addr;
                        a_dual_nxt = 1'b0;
                        d_dual_nxt = 1'b0;
                        dum_nxt    = 1'b0;
                    end else if (op_now == `SFRC_OP_FAST) begin
                        st_nxt     = ls_addr;
                        a_dual_nxt = 1'b0;
                        d_dual_nxt = 1'b0;
                        dum_nxt    = 1'b1;
                    end else if (op_now == `SFRC_OP_DUAL_OUTPUT_READ_CMD) begin
                        st_nxt     = ls_addr;
                        a_dual_nxt = 1'b0;
                        d_dual_nxt = 1'b1;
                        dum_nxt    = 1'b1;
                    end else if (op_now == `SFRC_OP_DIO) begin
                        st_nxt     = ls_addr;
                        a_dual_nxt = 1'b1;
                        d_dual_nxt = 1'b1;
                        dum_nxt    = 1'b0;
                    end
                end
            end
            ls_addr: begin
                addr_nxt = addr_sh;
                if (ph_inc == (a_dual_r ? `SFRC_ADDR_X2 : `SFRC_ADDR_X1)) begin
                    ph_nxt = 5'd0;
                    if (!a_dual_r) begin
                        st_nxt = dum_r ? ls_dummy : ls_data;
                    end else if (bsy_s2_r && op_r == 8'h00) begin
                        st_nxt = ls_ign;                                 // continuous frame while busy
                    end else begin
                        st_nxt = ls_mode;
                    end
                end
            end
            ls_mode: begin
                if (mode_end) begin
                    ph_nxt = 5'd0;
                    st_nxt = ls_data;
                end
            end
            ls_dummy: begin
                if (ph_inc == `SFRC_DUMMY_CLK) begin
                    ph_nxt = 5'd0;
                    st_nxt = ls_data;
                end
            end
            ls_data: begin
                ph_nxt   = ph_r;
                dcnt_nxt = (dcnt_r == dmax) ? 3'd0 : dcnt_r + 3'd1;
                if (dcnt_r == 3'd0) begin
                    addr_nxt = addr_inc;                                 // next byte fetched
                end
            end
            default: begin
                ph_nxt = ph_r;
            end
        endcase
    end

    // frame registers, cleared while chip select is high
    always_ff @(posedge i_sclk or posedge frame_rst) begin
        if (frame_rst) begin
            st_r     <= ls_start;
            ph_r     <= 5'd0;
            tot_r    <= 5'd0;
            opc_r    <= 8'h00;
            op_r     <= 8'h00;
            ign_r    <= 8'h00;
            addr_r   <= 24'h0;
            a_dual_r <= 1'b0;
            d_dual_r <= 1'b0;
            dum_r    <= 1'b0;
            dcnt_r   <= 3'd0;
        end else begin
            st_r     <= st_nxt;
            ph_r     <= ph_nxt;
            tot_r    <= tot_inc;
            opc_r    <= op_now;
            op_r     <= op_nxt;
            ign_r    <= (st_r == ls_mode) ? {ign_r[5:0], i_io1, i_io0} : {ign_r[6:0], i_io0};
            addr_r   <= addr_nxt;
            a_dual_r <= a_dual_nxt;
            d_dual_r <= d_dual_nxt;
            dum_r    <= dum_nxt;
            dcnt_r   <= dcnt_nxt;
        end
    end

    // persistent link state: continuous mode and frame results
    always_ff @(posedge i_sclk or posedge i_rst) begin
        if (i_rst) begin
            cont_r     <= 1'b0;
            frm_tgl_r  <= 1'b0;
            res_write_enable_cmd_r <= 1'b0;
            res_wrdi_r <= 1'b0;
            res_cfg_r  <= 1'b0;
            res_byte_r <= 8'h00;
        end else begin
            if (mode_end) begin
                cont_r <= (ign_r[3:2] == `SFRC_KEY_CONT);
            end else if (opc_end && op_now == `SFRC_OP_MRST) begin
                cont_r <= 1'b0;
            end
            if (st_r == ls_start) begin
                frm_tgl_r <= ~frm_tgl_r;
            end
            res_write_enable_cmd_r <= opc_end && (op_now == `SFRC_OP_WRITE_ENABLE_CMD);
            res_wrdi_r <= opc_end && (op_now == `SFRC_OP_WRDI);
            // exactly one data byte after the opcode
            res_cfg_r  <= (st_r == ls_ign) && (op_r == `SFRC_OP_CFGWR) && (tot_r == `SFRC_CFG_CLK - 5'd1);
            if ((st_r == ls_ign) && (tot_r == `SFRC_CFG_CLK - 5'd1)) begin
                res_byte_r <= {ign_r[6:0], i_io0};
            end
        end
    end

    // array read on the address the frame logic is about to hold
    sfrc_mem #(
        .AW (ADDR_W),
        .DW (8)
    ) u_mem (
        .i_wclk  (i_clk),
        .i_we    (i_ld_we),
        .i_waddr (i_ld_addr),
        .i_wdata (i_ld_data),
        .i_rclk  (i_sclk),
        .i_raddr (addr_nxt[ADDR_W-1:0]),
        .o_rdata (mem_q)
    );

    // data shifted out on falling edges
    always_ff @(negedge i_sclk or posedge frame_rst) begin
        if (frame_rst) begin
            dout_r <= 8'h00;
            drv_r  <= 1'b0;
            ncnt_r <= 3'd0;
        end else if (st_r == ls_data) begin
            drv_r  <= 1'b1;
            ncnt_r <= (ncnt_r == dmax) ? 3'd0 : ncnt_r + 3'd1;
            if (ncnt_r == 3'd0) begin
                dout_r <= mem_q;
            end else if (d_dual_r) begin
                dout_r <= {dout_r[5:0], 2'b00};
            end else begin
                dout_r <= {dout_r[6:0], 1'b0};
            end
        end
    end

    // pin drive: released outside the data phase
    assign o_io1      = dout_r[7];
    assign o_io0      = dout_r[6];
    assign o_io1_oe_n = ~drv_r;
    assign o_io0_oe_n = ~(drv_r & d_dual_r);

    // ---------------------------------------------------------------
    // system domain: frame end detection
    // ---------------------------------------------------------------
    logic            cs_s1_r, cs_s2_r, cs_s3_r, tg_s1_r, tg_s2_r, seen_r;
    logic            busy_r, wel_r;
    logic [TW_W-1:0] tmr_r;
    logic [7:0]      pend_r, cfg_reg_r, b0_r, b1_r;
    logic [1:0]      buf_cnt_r;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_s3_r <= 1'b1;
            tg_s1_r <= 1'b0;
            tg_s2_r <= 1'b0;
        end else begin
            cs_s1_r <= i_cs_n;
            cs_s2_r <= cs_s1_r;
            cs_s3_r <= cs_s2_r;
            tg_s1_r <= frm_tgl_r;
            tg_s2_r <= tg_s1_r;
        end
    end

    wire new_frm   = cs_s2_r && !cs_s3_r && (tg_s2_r != seen_r);
    wire buf_pop   = o_cfg_valid && i_cfg_ready;
    wire tw_done   = busy_r && (tmr_r == '0);
    // accepted only with latch set, idle array and room in the buffer
    wire cfg_start = new_frm && res_cfg_r && wel_r && !busy_any_r && (buf_cnt_r != 2'd2);
    wire busy_nxt  = cfg_start || (busy_r && !tw_done);
    wire [1:0] fill = buf_cnt_r - {1'b0, buf_pop};

    // latch, busy flag and self-timed cycle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            seen_r     <= 1'b0;
            wel_r      <= 1'b0;
            busy_r     <= 1'b0;
            busy_any_r <= 1'b0;
            tmr_r      <= '0;
            pend_r     <= 8'h00;
            cfg_reg_r  <= 8'h00;
        end else begin
            if (new_frm) begin
                seen_r <= tg_s2_r;
            end
            if (new_frm && res_write_enable_cmd_r) begin
                wel_r <= 1'b1;
            end else if (tw_done || (new_frm && res_wrdi_r)) begin
                wel_r <= 1'b0;
            end
            busy_r     <= busy_nxt;
            busy_any_r <= busy_nxt | i_ext_busy;
            if (cfg_start) begin
                tmr_r  <= TW_W'(TW_CYCLES - 1);
                pend_r <= res_byte_r;
            end else if (busy_r) begin
                tmr_r <= tmr_r - 1'b1;
            end
            if (tw_done) begin
                cfg_reg_r <= pend_r;
            end
        end
    end

    // two-entry buffer of written configuration bytes
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            b0_r      <= 8'h00;
            b1_r      <= 8'h00;
            buf_cnt_r <= 2'd0;
        end else begin
            if (buf_pop) begin
                b0_r <= b1_r;
            end
            if (tw_done && fill == 2'd0) begin
                b0_r <= pend_r;
            end else if (tw_done) begin
                b1_r <= pend_r;
            end
            buf_cnt_r <= fill + {1'b0, tw_done};
        end
    end

    assign o_busy_flag = busy_any_r;
    assign o_wel       = wel_r;
    assign o_cfg_reg   = cfg_reg_r;
    assign o_cfg_valid = (buf_cnt_r != 2'd0);
    assign o_cfg_data  = b0_r;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    chk_cfg_needs_wel: assert property (@(posedge i_clk) disable iff (i_rst)
        cfg_start |-> wel_r && !busy_r) else $error("config write without latch");
    chk_write_enable_cmd_sets_wel: assert property (@(posedge i_clk) disable iff (i_rst)
        (new_frm && res_write_enable_cmd_r) |=> wel_r) else $error("latch not set");
    chk_busy_on_start: assert property (@(posedge i_clk) disable iff (i_rst)
        cfg_start |=> busy_r ##0 o_busy_flag) else $error("busy not raised");
    chk_busy_holds_len: assert property (@(posedge i_clk) disable iff (i_rst)
        ($rose(busy_r) && TW_CYCLES >= 8) |-> busy_r[*8]) else $error("busy dropped early");
    chk_done_clears_wel: assert property (@(posedge i_clk) disable iff (i_rst)
        (tw_done && !(new_frm && res_write_enable_cmd_r)) |=> !wel_r && !busy_r) else $error("latch kept");
    chk_busy_readable: assert property (@(posedge i_clk) disable iff (i_rst)
        busy_r |-> o_busy_flag) else $error("busy flag hidden");
    chk_hiz_outside_data: assert property (@(posedge i_sclk) disable iff (i_rst || i_cs_n)
        (st_r != ls_data) |-> o_io1_oe_n && o_io0_oe_n) else $error("pin driven early");
    chk_gated_ignore: assert property (@(posedge i_sclk) disable iff (i_rst || i_cs_n)
        (opc_end && gated_rd(op_now) && bsy_s2_r) |=> st_r == ls_ign) else $error("read taken while busy");
    chk_cont_entry: assert property (@(posedge i_sclk) disable iff (i_rst || i_cs_n)
        (st_r == ls_start && cont_r && !bsy_s2_r) |=> st_r == ls_addr && a_dual_r) else $error("no continuous");
    chk_addr_wrap: assert property (@(posedge i_sclk) disable iff (i_rst || i_cs_n)
        (st_r == ls_data && dcnt_r == 3'd0 && addr_r[ADDR_W-1:0] == '1) |=> addr_r[ADDR_W-1:0] == '0)
        else $error("address did not wrap");
    chk_single_io0_free: assert property (@(posedge i_sclk) disable iff (i_rst || i_cs_n)
        (st_r == ls_data && !d_dual_r) |-> o_io0_oe_n) else $error("io0 driven in single read");

    cov_cfg_write: cover property (@(posedge i_clk) disable iff (i_rst) tw_done);
    cov_cont_frame: cover property (@(posedge i_sclk) disable iff (i_rst || i_cs_n)
        st_r == ls_start && cont_r);
    cov_dual_data: cover property (@(posedge i_sclk) disable iff (i_rst || i_cs_n)
        st_r == ls_data && d_dual_r && dcnt_r == 3'd3);

endmodule // sfrc_seq
`default_nettype wire

/* sfrc_seq_tb_top.sv */
// testbench for the serial flash read and config write sequencer
`timescale 1ns/1ps
`default_nettype none
module sfrc_seq_tb_top;
    localparam int AW = 8;
    logic i_clk = 1'b0, i_rst = 1'b1, ext_busy = 1'b0, ld_we = 1'b0, cfg_rdy = 1'b0;
    logic [AW-1:0] ld_addr = '0;
    logic [7:0] ld_data = 8'h00;
    wire sclk, cs_n, h0, h1, d0, d1, oe0_n, oe1_n, busy, write_enable_latch, cvalid;
    wire [7:0] creg, cdata;
    wire w0 = !oe0_n ? d0 : h0;
    wire w1 = !oe1_n ? d1 : h1;
    int miscompares = 0, n_checks = 0;
    always #2.5 i_clk = ~i_clk;
    sfrc_seq #(.ADDR_W(AW), .TW_CYCLES(40)) sfrc_seq_inst (.i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk),
        .i_cs_n(cs_n), .i_io0(w0), .i_io1(w1), .o_io0(d0), .o_io0_oe_n(oe0_n), .o_io1(d1),
        .o_io1_oe_n(oe1_n), .i_ext_busy(ext_busy), .i_ld_we(ld_we), .i_ld_addr(ld_addr),
        .i_ld_data(ld_data), .o_busy_flag(busy), .o_wel(write_enable_latch), .o_cfg_reg(creg), .o_cfg_valid(cvalid),
        .o_cfg_data(cdata), .i_cfg_ready(cfg_rdy));
    sfrc_host sfrc_host_inst (.o_sclk(sclk), .o_cs_n(cs_n), .o_io0(h0), .o_io1(h1), .i_io0(w0), .i_io1(w1));
    // ------------------------------------------------
    // checking and closing
    // ------------------------------------------------
    function automatic logic [7:0] pat(input int a);
        return 8'(a * 37 + 17);
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wait_busy(input logic lvl);
        int k;
        for (k = 0; k < 200 && busy !== lvl; k++) @(negedge i_clk);
        if (k == 200) begin
            miscompares++;
            final_report();
        end
    endtask
    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    // read frame; op 00 is a continuous frame without opcode
    task automatic rd(input logic [7:0] op, input int a, input logic [7:0] m, input int n, input bit ok);
        logic [7:0] v;
        bit da;
        da = (op == 8'hbb) || (op == 8'h00);
        sfrc_host_inst.open_f();
        if (op != 8'h00) sfrc_host_inst.tx1(op);
        for (int i = 2; i >= 0; i--) begin
            if (da) sfrc_host_inst.tx2(8'(a >> (8 * i)));
            else sfrc_host_inst.tx1(8'(a >> (8 * i)));
        end
        if (da) sfrc_host_inst.tx2(m);
        if (op == 8'h0b || op == 8'h3b) sfrc_host_inst.tx1(8'h00);
        for (int i = 0; i < n; i++) begin
            sfrc_host_inst.rx(da || op == 8'h3b, v);
            if (ok) chk(v, pat((a + i) % (1 << AW)));
            else chk({6'h00, oe1_n, oe0_n}, 8'h03);
        end
        sfrc_host_inst.close_f();
        chk({6'h00, oe1_n, oe0_n}, 8'h03);
    endtask
    task automatic cmd(input logic [7:0] op);
        sfrc_host_inst.open_f();
        sfrc_host_inst.tx1(op);
        sfrc_host_inst.close_f();
        repeat (10) @(negedge i_clk);
    endtask
    // config write; extra sends a ninth data bit
    task automatic cfg(input logic [7:0] d, input bit extra, input bit ok);
        logic [7:0] old;
        old = creg;
        sfrc_host_inst.open_f();
        sfrc_host_inst.tx1(8'h01);
        sfrc_host_inst.tx1(d);
        if (extra) sfrc_host_inst.bit2(1'b0, 1'b0);
        sfrc_host_inst.close_f();
        if (ok) begin
            wait_busy(1'b1);
            wait_busy(1'b0);
        end else repeat (60) @(negedge i_clk);
        chk(creg, ok ? d : old);
        chk({7'h00, busy}, 8'h00);
    endtask
    task automatic pop(input logic [7:0] exp);
        chk({7'h00, cvalid}, 8'h01);
        chk(cdata, exp);
        cfg_rdy = 1'b1;
        @(negedge i_clk);
        cfg_rdy = 1'b0;
        @(negedge i_clk);
    endtask
    // ------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------
    initial begin
        repeat (100000) @(posedge i_clk);
        miscompares++;
        final_report();
    end
    initial begin
        repeat (20) @(negedge i_clk);
        i_rst = 1'b0;
        for (int a = 0; a < (1 << AW); a++) begin
            ld_we = 1'b1;
            ld_addr = AW'(a);
            ld_data = pat(a);
            @(negedge i_clk);
        end
        ld_we = 1'b0;
        rd(8'h03, 254, 8'h00, 4, 1'b1);
        rd(8'h0b, 5, 8'h00, 2, 1'b1);
        rd(8'h3b, 3, 8'h00, 2, 1'b1);
        rd(8'hbb, 7, 8'h20, 2, 1'b1);
        rd(8'h00, 9, 8'h20, 2, 1'b1);
        // continuous frame refused while busy, mode kept
        @(negedge i_clk) ext_busy = 1'b1;
        rd(8'h00, 4, 8'h20, 1, 1'b0);
        @(negedge i_clk) ext_busy = 1'b0;
        sfrc_host_inst.open_f();
        repeat (4) sfrc_host_inst.tx2(8'hff);
        sfrc_host_inst.close_f();
        rd(8'h03, 2, 8'h00, 1, 1'b1);
        rd(8'hbb, 11, 8'h00, 1, 1'b1);
        rd(8'h03, 12, 8'h00, 1, 1'b1);
        @(negedge i_clk) ext_busy = 1'b1;
        repeat (10) @(negedge i_clk);
        rd(8'h0b, 1, 8'h00, 1, 1'b0);
        rd(8'h3b, 1, 8'h00, 1, 1'b0);
        rd(8'hbb, 1, 8'h00, 1, 1'b0);
        @(negedge i_clk) ext_busy = 1'b0;
        repeat (10) @(negedge i_clk);
        cfg(8'h5a, 1'b0, 1'b0);
        cmd(8'h06);
        chk({7'h00, write_enable_latch}, 8'h01);
        cfg(8'h11, 1'b1, 1'b0);
        cfg(8'ha5, 1'b0, 1'b1);
        chk({7'h00, write_enable_latch}, 8'h00);
        cmd(8'h06);
        cfg(8'h3c, 1'b0, 1'b1);
        cmd(8'h06);
        cfg(8'h77, 1'b0, 1'b0);
        pop(8'ha5);
        pop(8'h3c);
        chk({7'h00, cvalid}, 8'h00);
        final_report();
    end
endmodule // sfrc_seq_tb_top
`default_nettype wire
